// ### hdl/iwr_pkg.sv
// Purpose: Shared constants for interrupt priority and stop wake routing
// Assumes: 32 interrupt sources, 8 priority words, APB register access
// Notes:   Offsets are byte addresses of aligned 32-bit words
package iwr_pkg;
	localparam int NUM_IRQ        = 32;
	localparam int NUM_PRIO_REG   = 8;
	localparam int IRQ_PER_REG    = 4;
	localparam int FIELD_STRIDE   = 8;
	localparam int FIELD_BASE     = 6;
	localparam int FIELD_WIDTH    = 2;

	localparam logic [4:0] SPI_IRQ_NUM       = 5'h0A;
	localparam logic [7:0] SPI_VECTOR_NUM    = 8'h1A;
	localparam logic [31:0] SPI_VECTOR_ADDR  = 32'h0000_0068;

	localparam logic [11:0] OFS_PRIO_BASE    = 12'h000;
	localparam logic [11:0] OFS_CTRL         = 12'h020;
	localparam logic [11:0] OFS_STATUS       = 12'h024;
	localparam logic [11:0] OFS_WAKE_PEND    = 12'h028;
	localparam logic [11:0] OFS_PIN_FLAGS    = 12'h02C;
	localparam logic [11:0] OFS_MOD_FLAGS    = 12'h030;

	localparam int CTRL_PIN_EN_LSB  = 0;
	localparam int CTRL_MOD_EN_LSB  = 16;
	localparam int CTRL_NMI_EN_BIT  = 24;
	localparam int CTRL_RST_EN_BIT  = 25;
	localparam int CTRL_MODE_LSB    = 28;

	localparam logic [31:0] CTRL_RESET      = 32'h0000_0000;
	localparam logic [7:0]  MOD_FLAG_USED   = 8'hB3;

	// Index of module wake flags
	localparam int MF_LPTMR = 0;
	localparam int MF_CMP   = 1;
	localparam int MF_TSI   = 4;
	localparam int MF_ALARM = 5;
	localparam int MF_SECS  = 7;

	// Wake pins 5..10, 14, 15 kept at their own bit positions in 16 slots
	localparam logic [15:0] WAKE_PIN_USED = 16'hC7E0;

	typedef enum logic [2:0] {
		IWR_RUN       = 3'b000,
		IWR_STOP      = 3'b001,
		IWR_LOW_LEAK  = 3'b010,
		IWR_VLLS1     = 3'b011,
		IWR_LEVEL2_BAD = 3'b100,
		IWR_VLLS3     = 3'b101
	} iwr_mode_e;

	// Async wake request vector bit positions
	localparam int AW_PORT  = 0;
	localparam int AW_LVD   = 1;
	localparam int AW_LVW   = 2;
	localparam int AW_UART0 = 3;
	localparam int AW_TPM   = 4;
	localparam int AW_LPTMR = 5;
	localparam int AW_CMP   = 6;
	localparam int AW_I2C   = 7;
	localparam int AW_SPI   = 8;
	localparam int AW_URXD  = 9;
	localparam int AW_RST   = 10;
	localparam int AW_RTC   = 11;
	localparam int AW_TSI   = 12;
	localparam int AW_ADC   = 13;
	localparam int AW_NMI   = 14;
	localparam int AW_COUNT = 15;
endpackage

// ### hdl/iwr_sync.sv
// Purpose: Three-stage synchroniser for asynchronous wake inputs
// Assumes: Inputs come from pins or other clock domains
// Notes:   Output changes only when stages two and three agree
`timescale 1ns/100ps
module iwr_sync #(
	parameter int W = 1
) (
	input  wire logic         pclk,
	input  wire logic         presetn,
	input  wire logic [W-1:0] async_in,
	output logic      [W-1:0] sync_out
);
	logic [W-1:0] stage1;
	logic [W-1:0] stage2;
	logic [W-1:0] stage3;
	logic [W-1:0] next_out;

	assign next_out = (stage2 & stage3) | (sync_out & (stage2 | stage3));

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stage1   <= '0;
			stage2   <= '0;
			stage3   <= '0;
			sync_out <= '0;
		end else begin
			stage1   <= async_in;
			stage2   <= stage1;
			stage3   <= stage2;
			sync_out <= next_out;
		end
	end
endmodule

// ### hdl/iwr_prio_field.sv
// Purpose: Locate one interrupt's priority field in the register bank
// Assumes: Interrupt number below the bank size
// Notes:   Pure combinational lookup
`timescale 1ns/100ps
module iwr_prio_field (
	input  wire logic [4:0]   irq_num,
	input  wire logic [255:0] prio_flat,
	output logic      [2:0]   reg_index,
	output logic      [4:0]   field_lsb,
	output logic      [1:0]   level
);
	logic [7:0] bit_pos;

	assign reg_index = irq_num[4:2];
	assign field_lsb = {irq_num[1:0], 3'b000} + 5'h06;
	assign bit_pos   = {reg_index, field_lsb};
	assign level     = prio_flat[bit_pos +: iwr_pkg::FIELD_WIDTH];
endmodule

// ### hdl/iwr_top.sv
// Purpose: Priority field store and stop wake routing behind an APB slave
// Assumes: Single 25 MHz clock, wake sources are asynchronous levels
// Notes:   Wake outputs are levels; no interrupt logic of its own
`timescale 1ns/100ps

module iwr_top (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic [31:0] irq_src,
	input  wire logic        port_pin_irq,
	input  wire logic        lvd_event,
	input  wire logic        lvw_event,
	input  wire logic        uart0_irq,
	input  wire logic        uart0_clk_en,
	input  wire logic        tpm_irq,
	input  wire logic        tpm_clk_en,
	input  wire logic        lptmr_irq,
	input  wire logic        lptmr_clk_en,
	input  wire logic        cmp_irq,
	input  wire logic        i2c_addr_match,
	input  wire logic        spi_slave_irq,
	input  wire logic        uart1_rxd_edge,
	input  wire logic        uart2_rxd_edge,
	input  wire logic        reset_pin,
	input  wire logic        reset_osc_clk,
	input  wire logic        rtc_alarm_irq,
	input  wire logic        rtc_seconds_irq,
	input  wire logic        tsi_irq,
	input  wire logic        adc_irq,
	input  wire logic        adc_int_clk,
	input  wire logic        nmi_pin,
	input  wire logic [15:0] external_wake_pin_input,
	input  wire logic        leakage_wake_unmasked,
	input  wire logic [4:0]  query_irq,
	output logic      [2:0]  query_reg_index,
	output logic      [4:0]  query_field_lsb,
	output logic      [1:0]  query_level,
	output logic      [31:0] irq_to_core,
	output logic      [1:0]  spi_irq_level,
	output logic      [31:0] spi_vector_addr,
	output logic      [2:0]  power_mode,
	output logic             stopped,
	output logic             async_wake_req,
	output logic             leakage_wake_req,
	output logic             pin_wake_exit
);
	localparam int NSYNC = 31;

	logic [31:0]  prio_reg [iwr_pkg::NUM_PRIO_REG];
	logic [255:0] prio_flat;
	logic [31:0]  ctrl;
	logic [7:0]   module_wake_flag;
	logic [15:0]  pin_flag;
	logic [NSYNC-1:0] raw_in;
	logic [NSYNC-1:0] syn;
	logic [iwr_pkg::AW_COUNT-1:0] aw_vec;
	logic [15:0]  pin_hit;
	logic [7:0]   mod_hit;
	logic [7:0]   mod_src;
	logic [31:0]  status_word;
	logic [31:0]  rd_mux;
	logic [2:0]   mode_req;
	logic [2:0]   next_mode;
	logic         wr_en;
	logic         rd_en;
	logic         hit_prio;
	logic         hit_ctrl;
	logic         hit_stat;
	logic         hit_pend;
	logic         hit_pin;
	logic         hit_mod;
	logic         addr_ok;
	logic         in_stop;
	logic         wake_any;
	logic         nmi_rst_wake;

	// All wake inputs except port pin, LVD, LVW, I2C, SPI and UART1/2 RXD cross in; clock enables treated like levels too
	assign raw_in = {external_wake_pin_input, adc_int_clk, adc_irq, tsi_irq,
			rtc_seconds_irq, rtc_alarm_irq, reset_osc_clk, reset_pin,
			nmi_pin, cmp_irq, lptmr_irq, lptmr_clk_en, tpm_clk_en,
			tpm_irq, uart0_clk_en, uart0_irq};

	iwr_sync #(
		.W (NSYNC)
	) u_sync (
		.pclk     (pclk),
		.presetn  (presetn),
		.async_in (raw_in),
		.sync_out (syn)
	);

	genvar gi;
	generate
		for (gi = 0; gi < iwr_pkg::NUM_PRIO_REG; gi++) begin : g_flat
			assign prio_flat[gi*32 +: 32] = prio_reg[gi];
		end
	endgenerate

	iwr_prio_field u_field (
		.irq_num   (query_irq),
		.prio_flat (prio_flat),
		.reg_index (query_reg_index),
		.field_lsb (query_field_lsb),
		.level     (query_level)
	);

	// Field of the combined serial interface interrupt
	assign spi_irq_level   = prio_reg[iwr_pkg::SPI_IRQ_NUM[4:2]][23:22];
	assign spi_vector_addr = iwr_pkg::SPI_VECTOR_ADDR;
	assign irq_to_core     = irq_src;

	// Port pin and voltage detect already sit in the clock domain of the mode logic
	assign aw_vec[iwr_pkg::AW_PORT]  = port_pin_irq;
	assign aw_vec[iwr_pkg::AW_LVD]   = lvd_event;
	assign aw_vec[iwr_pkg::AW_LVW]   = lvw_event;
	assign aw_vec[iwr_pkg::AW_UART0] = syn[0] & syn[1];
	assign aw_vec[iwr_pkg::AW_TPM]   = syn[2] & syn[3];
	assign aw_vec[iwr_pkg::AW_LPTMR] = syn[5] & syn[4];
	assign aw_vec[iwr_pkg::AW_CMP]   = syn[6];
	assign aw_vec[iwr_pkg::AW_I2C]   = i2c_addr_match;
	assign aw_vec[iwr_pkg::AW_SPI]   = spi_slave_irq;
	assign aw_vec[iwr_pkg::AW_URXD]  = uart1_rxd_edge | uart2_rxd_edge;
	assign aw_vec[iwr_pkg::AW_RST]   = syn[8] & syn[9];
	assign aw_vec[iwr_pkg::AW_RTC]   = syn[10] | syn[11];
	assign aw_vec[iwr_pkg::AW_TSI]   = syn[12];
	assign aw_vec[iwr_pkg::AW_ADC]   = syn[13] & syn[14];
	assign aw_vec[iwr_pkg::AW_NMI]   = syn[7];

	assign in_stop        = (power_mode != iwr_pkg::IWR_RUN);
	assign async_wake_req = in_stop & (|aw_vec);

	// Leakage unit: only documented pins and flags can hit
	assign pin_hit = syn[30:15] & ctrl[15:0] & iwr_pkg::WAKE_PIN_USED;
	assign mod_src[iwr_pkg::MF_LPTMR] = syn[5];
	assign mod_src[iwr_pkg::MF_CMP]   = syn[6];
	assign mod_src[2]                 = 1'b0;
	assign mod_src[3]                 = 1'b0;
	assign mod_src[iwr_pkg::MF_TSI]   = syn[12];
	assign mod_src[iwr_pkg::MF_ALARM] = syn[10];
	assign mod_src[6]                 = 1'b0;
	assign mod_src[iwr_pkg::MF_SECS]  = syn[11];
	assign mod_hit = mod_src & ctrl[23:16] & iwr_pkg::MOD_FLAG_USED;

	assign nmi_rst_wake = (ctrl[iwr_pkg::CTRL_NMI_EN_BIT] & syn[7]) |
			(ctrl[iwr_pkg::CTRL_RST_EN_BIT] & syn[8]);
	assign pin_wake_exit = in_stop & nmi_rst_wake;

	// A masked leakage interrupt blocks exit from low-leakage stop
	assign leakage_wake_req = (|pin_flag | |module_wake_flag) &
			((power_mode != iwr_pkg::IWR_LOW_LEAK) | leakage_wake_unmasked);
	assign wake_any = async_wake_req | leakage_wake_req | pin_wake_exit;
	assign stopped  = in_stop;

	// Unsupported level two or unknown codes leave the mode unchanged
	assign mode_req = pwdata[iwr_pkg::CTRL_MODE_LSB +: 3];
	assign next_mode = (mode_req == iwr_pkg::IWR_LEVEL2_BAD) ? power_mode :
			(mode_req > iwr_pkg::IWR_VLLS3) ? power_mode : mode_req;

	// APB decode
	assign pready   = 1'b1;
	assign wr_en    = psel & penable & pwrite;
	assign rd_en    = psel & penable & ~pwrite;
	assign hit_prio = (paddr[11:5] == 7'h00) & (paddr[1:0] == 2'b00);
	assign hit_ctrl = paddr == iwr_pkg::OFS_CTRL;
	assign hit_stat = paddr == iwr_pkg::OFS_STATUS;
	assign hit_pend = paddr == iwr_pkg::OFS_WAKE_PEND;
	assign hit_pin  = paddr == iwr_pkg::OFS_PIN_FLAGS;
	assign hit_mod  = paddr == iwr_pkg::OFS_MOD_FLAGS;
	assign addr_ok  = hit_prio | hit_ctrl | hit_stat | hit_pend | hit_pin | hit_mod;
	assign pslverr  = psel & penable & ~addr_ok;

	assign status_word = {25'h0000000, stopped, async_wake_req, leakage_wake_req,
			pin_wake_exit, power_mode};
	assign rd_mux = hit_prio ? (prio_reg[paddr[4:2]] & 32'hC0C0C0C0) :
			hit_ctrl ? (ctrl & 32'h73FF_C7E0 | {8'h00, 8'h00, 16'h0000}) :
			hit_stat ? status_word :
			hit_pend ? {17'h00000, aw_vec} :
			hit_pin  ? {16'h0000, pin_flag} :
			hit_mod  ? {24'h000000, module_wake_flag} : 32'h0000_0000;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < iwr_pkg::NUM_PRIO_REG; i++) begin
				prio_reg[i] <= 32'h0000_0000;
			end
		end else if (wr_en && hit_prio) begin
			prio_reg[paddr[4:2]] <= pwdata & 32'hC0C0C0C0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl <= iwr_pkg::CTRL_RESET;
		end else if (wr_en && hit_ctrl) begin
			ctrl <= pwdata;
		end
	end

	// Mode falls back to run on any wake
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			power_mode <= iwr_pkg::IWR_RUN;
		end else if (in_stop && wake_any) begin
			power_mode <= iwr_pkg::IWR_RUN;
		end else if (wr_en && hit_ctrl) begin
			power_mode <= next_mode;
		end else begin
			power_mode <= power_mode;
		end
	end

	// Sticky flags: write one clears, a new hit wins over the clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_flag         <= 16'h0000;
			module_wake_flag <= 8'h00;
		end else begin
			pin_flag <= (pin_flag & ~((wr_en && hit_pin) ? pwdata[15:0] : 16'h0000))
					| (in_stop ? pin_hit : 16'h0000);
			module_wake_flag <= (module_wake_flag &
					~((wr_en && hit_mod) ? pwdata[7:0] : 8'h00))
					| (in_stop ? mod_hit : 8'h00);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
		end else if (psel && !penable && !pwrite) begin
			prdata <= rd_mux;
		end else begin
			prdata <= prdata;
		end
	end
endmodule

// ### bench/iwr_monitor.sv
// Purpose: Port checker for priority lookup and stop wake routing
// Assumes: One clock, asynchronous active-low reset
// Notes:   Bound onto every iwr_top instance
`timescale 1ns/100ps
module iwr_monitor (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic [4:0]  query_irq,
	input wire logic [2:0]  query_reg_index,
	input wire logic [4:0]  query_field_lsb,
	input wire logic [31:0] spi_vector_addr,
	input wire logic [31:0] irq_src,
	input wire logic [31:0] irq_to_core,
	input wire logic [2:0]  power_mode,
	input wire logic        stopped,
	input wire logic        async_wake_req,
	input wire logic        pin_wake_exit,
	input wire logic        lvd_event,
	input wire logic        uart0_irq,
	input wire logic        uart0_clk_en
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence s_access; psel && penable; endsequence
	sequence s_lvd_stop; stopped && lvd_event; endsequence
	// Five samples: four flops of sync latency, then the request shows
	sequence s_uart0_stop; stopped && uart0_irq && uart0_clk_en; endsequence

	property p_reg_index; query_reg_index == query_irq[4:2]; endproperty
	property p_field_lsb; query_field_lsb == {query_irq[1:0], 3'h6}; endproperty
	property p_spi_vec; spi_vector_addr == 32'h0000_0068; endproperty
	property p_irq_pass; irq_to_core == irq_src; endproperty
	property p_mode_legal; power_mode != 3'h4; endproperty
	property p_lvd_wake; s_lvd_stop |-> async_wake_req; endproperty
	property p_wake_run; async_wake_req |=> power_mode == 3'h0; endproperty
	property p_uart0_wake; s_uart0_stop [*5] |-> async_wake_req; endproperty
	property p_pin_exit; stopped && pin_wake_exit |=> !stopped; endproperty
	property p_ready; s_access |-> pready; endproperty
	property p_slverr; pslverr |-> psel && penable; endproperty

	a_reg_index: assert property (p_reg_index) else $error("word index wrong");
	a_field_lsb: assert property (p_field_lsb) else $error("field lsb wrong");
	a_spi_vec: assert property (p_spi_vec) else $error("spi vector wrong");
	a_irq_pass: assert property (p_irq_pass) else $error("irq not passed");
	a_mode_legal: assert property (p_mode_legal) else $error("level two mode entered");
	a_lvd_wake: assert property (p_lvd_wake) else $error("lvd no wake");
	a_wake_run: assert property (p_wake_run) else $error("wake kept stop");
	a_uart0_wake: assert property (p_uart0_wake) else $error("uart0 no wake");
	a_pin_exit: assert property (p_pin_exit) else $error("pin exit kept stop");
	a_ready: assert property (p_ready) else $error("pready low");
	a_slverr: assert property (p_slverr) else $error("pslverr outside access");
endmodule
bind iwr_top iwr_monitor u_mon (.*);

// ### bench/iwr_src_model.sv
// Purpose: Peripheral interrupt and wake source model
// Assumes: Levels change just after a rising edge
// Notes:   Wake levels grouped in wk, clock gates in gt
`timescale 1ns/100ps
module iwr_src_model (
	input  wire logic        pclk,
	input  wire logic        presetn,
	output logic      [31:0] irq_src,
	output logic      [15:0] wk,
	output logic      [4:0]  gt,
	output logic      [15:0] external_wake_pin_input,
	output logic             leakage_wake_unmasked
);
	assign leakage_wake_unmasked   = 1'b1;
	initial begin
		wk                      = 16'h0000;
		gt                      = 5'h00;
		external_wake_pin_input = 16'h0000;
	end
	task drive_pin(input logic [15:0] v);
		@(posedge pclk);
		external_wake_pin_input <= v;
	endtask
	// Sources change every cycle so a stuck route shows
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_src <= 32'h0000_0000;
		end else begin
			irq_src <= irq_src + 32'h9E37_79B9;
		end
	end
	task drive_wk(input int i, input logic v);
		@(posedge pclk);
		wk[i] <= v;
	endtask
	task drive_gt(input int i, input logic v);
		@(posedge pclk);
		gt[i] <= v;
	endtask
endmodule

// ### bench/test_irq_priority_and_stop_wake_routing.sv
// Purpose: Self-checking bench for priority lookup and stop wake routing
// Assumes: APB slave answers with pready, wake inputs other than port pin, LVD, LVW, I2C, SPI and UART RXD synchronised inside
// Notes:   Register readback of priority bits expected masked to the top two bits of each byte
`timescale 1ns/100ps
module test_irq_priority_and_stop_wake_routing;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, rd_err;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd, irq_src, irq_to_core, spi_vector_addr;
	logic [15:0] wk, external_wake_pin_input;
	logic [4:0]  gt, query_irq, query_field_lsb;
	logic [2:0]  query_reg_index, power_mode;
	logic [1:0]  query_level, spi_irq_level;
	logic port_pin_irq, lvd_event, lvw_event, uart0_irq, uart0_clk_en, tpm_irq, tpm_clk_en;
	logic lptmr_irq, lptmr_clk_en, cmp_irq, i2c_addr_match, spi_slave_irq, uart1_rxd_edge;
	logic uart2_rxd_edge, reset_pin, reset_osc_clk, rtc_alarm_irq, rtc_seconds_irq, tsi_irq;
	logic adc_irq, adc_int_clk, nmi_pin, leakage_wake_unmasked, stopped, async_wake_req;
	logic leakage_wake_req, pin_wake_exit;
	int   fails = 0;
	int   comparisons = 0;
	int   cycles = 0;

	assign {adc_irq, tsi_irq, rtc_seconds_irq, rtc_alarm_irq, reset_pin, uart2_rxd_edge,
		uart1_rxd_edge, spi_slave_irq, i2c_addr_match, cmp_irq, lptmr_irq, tpm_irq,
		uart0_irq, lvw_event, lvd_event, port_pin_irq} = wk;
	assign {adc_int_clk, reset_osc_clk, lptmr_clk_en, tpm_clk_en, uart0_clk_en} = gt;

	iwr_top u_dut (.*);
	iwr_src_model u_src (.*);

	always #20 pclk = ~pclk;

	always @(posedge pclk) begin
		cycles <= cycles + 1;
		if (cycles == 6000) begin
			fails++;
			end_of_test();
		end
	end

	task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			fails++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task tick(input int n);
		repeat (n) @(posedge pclk);
	endtask

	task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd      = prdata;
		rd_err  = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	// Old flags cleared first so stale pending wakes cannot mask a miss
	task go_stop;
		apb(1'b1, iwr_pkg::OFS_PIN_FLAGS, 32'hFFFF_FFFF);
		apb(1'b1, iwr_pkg::OFS_MOD_FLAGS, 32'hFFFF_FFFF);
		apb(1'b1, iwr_pkg::OFS_CTRL, 32'h1000_0000);
		tick(1);
	endtask

	task t_prio;
		apb(1'b1, 12'h008, 32'h0FC0_BF7F);
		apb(1'b0, 12'h008, 32'h0000_0000);
		check("prio word", rd, 32'h00C0_8040);
		check("spi level", {30'h0, spi_irq_level}, 32'h3);
		for (int n = 0; n < 32; n++) begin
			query_irq <= n[4:0];
			tick(1);
			check("word index", {29'h0, query_reg_index}, n / 4);
			check("field lsb", {27'h0, query_field_lsb}, 8 * (n % 4) + 6);
			check("level", {30'h0, query_level},
				(n / 4 == 2) ? (32'h00C0_8040 >> (8 * (n % 4) + 6)) & 32'h3 : 0);
		end
		apb(1'b0, 12'h100, 32'h0000_0000);
		check("unmapped", {31'h0, rd_err}, 32'h1);
		$display("priority test done");
	endtask

	task t_modes;
		go_stop();
		check("stop mode", {29'h0, power_mode}, 32'h1);
		apb(1'b1, iwr_pkg::OFS_CTRL, 32'h4000_0000);
		tick(1);
		check("level2 refused", {29'h0, power_mode}, 32'h1);
		$display("mode test done");
	endtask

	task t_free;
		int idx[11] = '{0, 1, 2, 6, 7, 8, 9, 10, 12, 13, 14};
		foreach (idx[k]) begin
			go_stop();
			u_src.drive_wk(idx[k], 1'b1);
			tick(8);
			check("free wake", {29'h0, power_mode}, 32'h0);
			u_src.drive_wk(idx[k], 1'b0);
			tick(8);
		end
		$display("free wake test done");
	endtask

	task t_gated;
		int src[5] = '{3, 4, 5, 11, 15};
		foreach (src[k]) begin
			go_stop();
			u_src.drive_wk(src[k], 1'b1);
			tick(8);
			check("gated hold", {29'h0, power_mode}, 32'h1);
			u_src.drive_gt(k, 1'b1);
			tick(8);
			check("gated wake", {29'h0, power_mode}, 32'h0);
			u_src.drive_wk(src[k], 1'b0);
			u_src.drive_gt(k, 1'b0);
			tick(8);
		end
		$display("gated wake test done");
	endtask

	// Reset pin exit, all leakage pins at once, then module flags one source at a time
	task t_leak;
		int ms[5] = '{5, 6, 14, 12, 13};
		int mf[5] = '{0, 1, 4, 5, 7};
		apb(1'b1, iwr_pkg::OFS_CTRL, 32'h1200_0000);
		u_src.drive_wk(11, 1'b1);
		tick(8);
		check("reset pin exit", {29'h0, power_mode}, 32'h0);
		u_src.drive_wk(11, 1'b0);
		tick(8);
		apb(1'b1, iwr_pkg::OFS_CTRL, 32'h1000_FFFF);
		u_src.drive_pin(16'hFFFF);
		tick(8);
		check("pin wake", {29'h0, power_mode}, 32'h0);
		check("leak req", {31'h0, leakage_wake_req}, 32'h1);
		apb(1'b0, iwr_pkg::OFS_PIN_FLAGS, 32'h0000_0000);
		check("pin flags", rd, 32'h0000_C7E0);
		u_src.drive_pin(16'h0000);
		tick(8);
		apb(1'b1, iwr_pkg::OFS_PIN_FLAGS, 32'hFFFF_FFFF);
		apb(1'b0, iwr_pkg::OFS_PIN_FLAGS, 32'h0000_0000);
		check("pin clear", rd, 32'h0000_0000);
		foreach (ms[k]) begin
			apb(1'b1, iwr_pkg::OFS_MOD_FLAGS, 32'hFFFF_FFFF);
			apb(1'b1, iwr_pkg::OFS_CTRL, 32'h10FF_0000);
			u_src.drive_wk(ms[k], 1'b1);
			tick(8);
			apb(1'b0, iwr_pkg::OFS_MOD_FLAGS, 32'h0000_0000);
			check("module flag", rd, 32'h1 << mf[k]);
			check("module wake", {29'h0, power_mode}, 32'h0);
			u_src.drive_wk(ms[k], 1'b0);
			tick(8);
		end
		$display("leak wake test done");
	endtask

	task end_of_test;
		$display("comparisons %0d fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	initial begin
		pclk      = 1'b0;
		presetn   = 1'b0;
		psel      = 1'b0;
		penable   = 1'b0;
		pwrite    = 1'b0;
		paddr     = 12'h000;
		pwdata    = 32'h0000_0000;
		query_irq = 5'h00;
		nmi_pin   = 1'b0;
		tick(3);
		presetn <= 1'b1;
		t_prio();
		t_modes();
		t_free();
		t_gated();
		t_leak();
		end_of_test();
	end
endmodule
